// File: src/lpcd_defs.vh
// Purpose: constants for the command/address decoder
// Assumes: ten-bit command/address bus, two halves per command
// Notes:   command codes are on rising-half bits 3..0 (bit 0 first)
`ifndef LPCD_DEFS_VH
`define LPCD_DEFS_VH

`define LPCD_CA_W        10
// decoded command codes presented on cmd_code
`define LPCD_CMD_NONE    4'h0
`define LPCD_CMD_MRW     4'h1
`define LPCD_CMD_MRR     4'h2
`define LPCD_CMD_REFPB   4'h3
`define LPCD_CMD_REFAB   4'h4
`define LPCD_CMD_ACT     4'h5
`define LPCD_CMD_RD      4'h6
`define LPCD_CMD_WR      4'h7
`define LPCD_CMD_PRE     4'h8
`define LPCD_CMD_BST     4'h9
`define LPCD_CMD_SELF_REFRESH_MODE    4'hA
`define LPCD_CMD_DPD     4'hB
`define LPCD_CMD_PDE     4'hC
`define LPCD_CMD_PDX     4'hD
`define LPCD_CMD_NOP     4'hE
`define LPCD_CMD_ILLEGAL 4'hF
// power modes shown on power_mode
`define LPCD_PM_ACTIVE   2'h0
`define LPCD_PM_PD       2'h1
`define LPCD_PM_SELF_REFRESH_MODE     2'h2
`define LPCD_PM_DPD      2'h3

`endif

// File: src/lpcd_sync.v
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: nothing beyond a free-running clk
// Notes:   first stage is read only by the second
module lpcd_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {W{1'b0}};
			q    <= {W{1'b0}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // lpcd_sync

// File: src/lpcd_decoder.v
// Purpose: command/address decoder for a low-power DDR memory
// Assumes: true_clock much slower than clk; pins sampled through synchronisers
// Notes:   one-cycle cmd_valid per decoded command; fields held until next one
//          unknown codes, and per-bank refresh when BANKS is below 8, raise the sticky illegal_seen
`include "lpcd_defs.vh"

// Overview of operation
// (R1) unspecified sequences flagged illegal; recovery needs power-down and full re-init
// (R2) command identified from chip select, bits 0-3 and clock enable at rise
// (R3) chip select and clock enable sampled only on rising edges
// (R4) rise bits form first half, following fall bits form second half
// (R5) controller drives don't-care bits to valid levels; decoder ignores them
// (R6) bank_select taken from first-half bits 7-9; top bit unused on four banks (decoder copies bit 9 into bank_select for any BANKS)
// (R7) auto_precharge_flag in read/write second half requests bank precharge
// (R8) all_banks_flag in precharge targets every bank, bank_select ignored
// (R9) column bit zero implied zero; column_index starts at bit one
// (R10) per-bank refresh not for four-bank part; device reports it illegal
// (R11) self-refresh and deep power down exit seen from clock enable alone
// (R12) first-half codes decode mode write/read, refreshes, precharge, burst stop
// (R13) activate 01, read 101, write 100; fields from both halves
// (R14) mode write gives index and operand; mode read gives index only
// (R15) clock enable falling: self-refresh, deep power down or power down entry
// (R16) no-op when chip select high, or low with bits 0-2 high
// (R17) no-op never aborts an operation in progress
module lpcd_decoder #(
	parameter BANKS = 4
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        true_clock,
	input  wire        chip_select_n,
	input  wire        clock_enable_pin,
	input  wire [9:0]  cmd_addr_bus,
	output reg         cmd_valid,
	output reg  [3:0]  cmd_code,
	output reg  [2:0]  bank_select,
	output reg  [14:0] row_index,
	output reg  [11:0] column_index,
	output reg         auto_precharge_flag,
	output reg         all_banks_flag,
	output reg  [7:0]  mode_reg_index,
	output reg  [7:0]  mode_reg_operand,
	output reg  [1:0]  power_mode,
	output reg         illegal_seen
);
	// ST_HALF: first half taken, second half due at the next fall
	localparam ST_IDLE = 1'b0;
	localparam ST_HALF = 1'b1;

	wire       s_clk;
	wire       s_cs_n;
	wire       s_cke;
	wire [9:0] s_ca;

	////////////////////////////////////////////////////////////////////////////
	// link clock rides the same synchroniser as the pins so each half sees its
	// bits with equal latency; true_clock must stay well below clk/4
	lpcd_sync #(.W(13)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({true_clock, chip_select_n, clock_enable_pin, cmd_addr_bus}),
		.q     ({s_clk, s_cs_n, s_cke, s_ca})
	);

	////////////////////////////////////////////////////////////////////////////
	reg       clk_d;
	reg       state;
	reg       cke_prev;
	reg       cs_r;
	reg [9:0] ca_r;
	reg       cke_r;

	// edge pulses act as one-cycle enables for the two capture points
	wire rise = s_clk & ~clk_d;
	wire fall = ~s_clk & clk_d;

	////////////////////////////////////////////////////////////////////////////
	// classify the first half; returns a command code
	function [3:0] first_kind;
		input       cs_n;
		input       cke_p;
		input       cke_n;
		input [3:0] c;
		begin
			// clock enable held low: maintain the power mode
			if (!cke_p && !cke_n)
				first_kind = `LPCD_CMD_NOP;
			else if (!cke_p && cke_n)
				first_kind = `LPCD_CMD_PDX;
			// (R15) clock enable falling
			else if (cke_p && !cke_n) begin
				if (cs_n)
					first_kind = `LPCD_CMD_PDE;
				else if (c[2:0] == 3'b100)
					first_kind = `LPCD_CMD_SELF_REFRESH_MODE;
				else if (c[2:0] == 3'b011)
					first_kind = `LPCD_CMD_DPD;
				else
					first_kind = `LPCD_CMD_ILLEGAL;
			// (R16) no-op encodings
			end else if (cs_n || c[2:0] == 3'b111)
				first_kind = `LPCD_CMD_NOP;
			else if (c[1:0] == 2'b10)
				first_kind = `LPCD_CMD_ACT;
			else if (c[2:0] == 3'b101)
				first_kind = `LPCD_CMD_RD;
			else if (c[2:0] == 3'b001)
				first_kind = `LPCD_CMD_WR;
			else begin
				// (R12) first-half opcode table
				case (c)
					4'h0:    first_kind = `LPCD_CMD_MRW;
					4'h8:    first_kind = `LPCD_CMD_MRR;
					4'h4:    first_kind = `LPCD_CMD_REFPB;
					4'hC:    first_kind = `LPCD_CMD_REFAB;
					4'hB:    first_kind = `LPCD_CMD_PRE;
					4'h3:    first_kind = `LPCD_CMD_BST;
					default: first_kind = `LPCD_CMD_ILLEGAL;
				endcase
			end
		end
	endfunction

	// kind comes from latched first-half state only, so second-half bits
	// can never change the identity of a command
	wire [3:0] kind = first_kind(cs_r, cke_prev, cke_r, ca_r[3:0]);

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_d               <= 1'b0;
			state               <= ST_IDLE;
			cke_prev            <= 1'b0;
			cs_r                <= 1'b1;
			ca_r                <= 10'h000;
			cke_r               <= 1'b0;
			cmd_valid           <= 1'b0;
			cmd_code            <= `LPCD_CMD_NONE;
			bank_select         <= 3'h0;
			row_index           <= 15'h0000;
			column_index        <= 12'h000;
			auto_precharge_flag <= 1'b0;
			all_banks_flag      <= 1'b0;
			mode_reg_index      <= 8'h00;
			mode_reg_operand    <= 8'h00;
			// power down after reset; cke_prev resets low, so a first command with cke high reads as exit
			power_mode          <= `LPCD_PM_PD;
			illegal_seen        <= 1'b0;
		end else begin
			clk_d     <= s_clk;
			cmd_valid <= 1'b0;
			// (R11) asynchronous exit; wins over a pending half, so a cut frame
			// is dropped rather than misread
			if (s_cke && (power_mode == `LPCD_PM_SELF_REFRESH_MODE || power_mode == `LPCD_PM_DPD)) begin
				power_mode <= `LPCD_PM_ACTIVE;
				cke_prev   <= 1'b1;
				cmd_valid  <= 1'b1;
				cmd_code   <= `LPCD_CMD_PDX;
				state      <= ST_IDLE;
				// (R1) deep power down exit ends the illegal episode
				if (power_mode == `LPCD_PM_DPD)
					illegal_seen <= 1'b0;
			end else if (rise) begin
				// (R3) cs/cke rise only
				// second-half select level is never looked at; enable is watched only by the self-refresh/deep power down exit above
				cs_r     <= s_cs_n;
				cke_r    <= s_cke;
				// (R4) first half capture
				ca_r     <= s_ca;
				state    <= ST_HALF;
			end else if (fall && state == ST_HALF) begin
				state    <= ST_IDLE;
				// cke of this rise becomes the previous level for the next command
				cke_prev <= cke_r;
				// (R2) decode at fall
				cmd_valid <= 1'b1;
				cmd_code  <= kind;
				// fields are written only by the commands that own them
				case (kind)
					`LPCD_CMD_MRW, `LPCD_CMD_MRR: begin
						// (R14) index and operand
						mode_reg_index <= {s_ca[1:0], ca_r[9:4]};
						if (kind == `LPCD_CMD_MRW)
							mode_reg_operand <= s_ca[9:2];
					end
					`LPCD_CMD_ACT: begin
						// (R13) row assembly
						row_index   <= {s_ca[9:8], ca_r[6:2], s_ca[7:0]};
						bank_select <= ca_r[9:7];
					end
					`LPCD_CMD_RD, `LPCD_CMD_WR: begin
						// (R9) column bit zero
						column_index        <= {s_ca[9:1], ca_r[6:5], 1'b0};
						// (R6) bank field
						bank_select         <= ca_r[9:7];
						// (R7) auto precharge
						auto_precharge_flag <= s_ca[0];
					end
					`LPCD_CMD_PRE: begin
						// (R8) all banks
						all_banks_flag <= ca_r[4];
						bank_select    <= ca_r[4] ? 3'h0 : ca_r[9:7];
					end
					`LPCD_CMD_REFPB: begin
						// (R10) four-bank part refuses per-bank refresh
						if (BANKS < 8) begin
							cmd_code     <= `LPCD_CMD_ILLEGAL;
							illegal_seen <= 1'b1;
						end
					end
					// (R15) power entries, and power-down exit
					`LPCD_CMD_SELF_REFRESH_MODE: power_mode <= `LPCD_PM_SELF_REFRESH_MODE;
					`LPCD_CMD_DPD:  power_mode <= `LPCD_PM_DPD;
					`LPCD_CMD_PDE:  power_mode <= `LPCD_PM_PD;
					`LPCD_CMD_PDX:  power_mode <= `LPCD_PM_ACTIVE;
					// (R1) sticky until deep power down exit
					`LPCD_CMD_ILLEGAL: illegal_seen <= 1'b1;
					// (R16) (R17) no-op keeps all state
					default: ;
				endcase
			end
		end
	end
endmodule // lpcd_decoder

// File: verification/lpcd_decoder_assertions.sv
// Purpose: port checks for the command decoder
// Assumes: codes from lpcd_defs.vh
// Notes:   fields and modes move only with cmd_valid
`include "lpcd_defs.vh"
module lpcd_chk (
	input logic        clk,
	input logic        rst_n,
	input logic        clock_enable_pin,
	input logic        cmd_valid,
	input logic [3:0]  cmd_code,
	input logic [2:0]  bank_select,
	input logic [14:0] row_index,
	input logic [11:0] column_index,
	input logic        all_banks_flag,
	input logic [1:0]  power_mode,
	input logic        illegal_seen
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	pulse_once_a: assert property (cmd_valid |=> !cmd_valid) else $error("long pulse");
	nop_hold_a: assert property (cmd_valid && cmd_code == `LPCD_CMD_NOP
		|-> $stable(row_index) && $stable(column_index)) else $error("nop moved fields");
	col_zero_a: assert property (column_index[0] == 1'b0) else $error("col bit0");
	ab_bank_a: assert property (cmd_valid && cmd_code == `LPCD_CMD_PRE && all_banks_flag
		|-> bank_select == 3'h0) else $error("bank not ignored");
	illegal_flag_a: assert property (cmd_valid && cmd_code == `LPCD_CMD_ILLEGAL
		|-> illegal_seen) else $error("illegal not flagged");
	illegal_hold_a: assert property (illegal_seen && power_mode != `LPCD_PM_DPD
		|=> illegal_seen) else $error("illegal cleared");
	self_refresh_mode_exit_a: assert property (power_mode == `LPCD_PM_SELF_REFRESH_MODE && clock_enable_pin
		|-> ##[1:5] (cmd_valid && cmd_code == `LPCD_CMD_PDX)) else $error("no exit");
	mode_cmd_a: assert property ($changed(power_mode) |-> cmd_valid) else $error("mode");
	cover property (cmd_valid && cmd_code == `LPCD_CMD_RD);
	cover property (cmd_valid && cmd_code == `LPCD_CMD_PDX);
	cover property (illegal_seen);
endmodule // lpcd_chk
bind lpcd_decoder lpcd_chk u_lpcd_chk (.clk, .rst_n, .clock_enable_pin, .cmd_valid, .cmd_code,
	.bank_select, .row_index, .column_index, .all_banks_flag, .power_mode, .illegal_seen);

// File: verification/lpcd_ctrl.sv
// Purpose: memory controller model on the command/address pins
// Assumes: called from the bench, moves on clk falling edges
// Notes:   true_clock stands low between commands
module lpcd_ctrl (
	input  logic       clk,
	output logic       true_clock,
	output logic       chip_select_n,
	output logic       clock_enable_pin,
	output logic [9:0] cmd_addr_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
		{true_clock, chip_select_n, clock_enable_pin, cmd_addr_bus} = 13'h0800;
	task automatic send(input logic cs, ke, input logic [9:0] r, f);
		@(negedge clk);
		{chip_select_n, clock_enable_pin, cmd_addr_bus} = {cs, ke, r};
		@(negedge clk);
		true_clock = 1'b1;
		repeat (3) @(negedge clk);
		// select flipped for the fall half
		{chip_select_n, cmd_addr_bus} = {~cs, f};
		@(negedge clk);
		true_clock = 1'b0;
		repeat (4) @(negedge clk);
		// held bits go to a defined inverse
		cmd_addr_bus = ~f;
	endtask
	task automatic cke_up;
		@(negedge clk);
		clock_enable_pin = 1'b1;
	endtask
endmodule // lpcd_ctrl

// File: verification/tb_lpcd_decoder.sv
// Purpose: self-checking bench for the command decoder
// Assumes: one command per true_clock period
// Notes:   digests compare the fields each code writes
`include "lpcd_defs.vh"
module tb_lpcd_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, true_clock, chip_select_n, clock_enable_pin, cmd_valid;
	logic auto_precharge_flag, all_banks_flag, illegal_seen;
	logic [9:0] cmd_addr_bus, r, f;
	logic [3:0] cmd_code, got;
	logic [2:0] bank_select;
	logic [14:0] row_index;
	logic [11:0] column_index, e;
	logic [7:0] mode_reg_index, mode_reg_operand;
	logic [1:0] power_mode;
	int n_mismatch = 0, n_tests = 0, nv = 0, n0;
	// code, opcode mask, opcode value
	localparam logic [11:0] T [11] = '{12'h1F0, 12'h2F8, 12'hFF4, 12'h4FC, 12'h532, 12'h675,
		12'h771, 12'h8FB, 12'h9F3, 12'hE77, 12'hE00};
	lpcd_decoder u_lpcd_decoder (.clk, .rst_n, .true_clock, .chip_select_n, .clock_enable_pin,
		.cmd_addr_bus, .cmd_valid, .cmd_code, .bank_select, .row_index, .column_index,
		.auto_precharge_flag, .all_banks_flag, .mode_reg_index, .mode_reg_operand, .power_mode,
		.illegal_seen);
	lpcd_ctrl u_lpcd_ctrl (.clk, .true_clock, .chip_select_n, .clock_enable_pin, .cmd_addr_bus);
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (cmd_valid === 1'b1) begin
		got <= cmd_code;
		nv <= nv + 1;
	end
	function automatic logic [31:0] dig(logic [3:0] c, logic [9:0] r, f);
		case (c)
			1: return {f[1:0], r[9:4], f[9:2]};
			2: return {f[1:0], r[9:4]};
			5: return {r[9:7], f[9:8], r[6:2], f[7:0]};
			6, 7: return {r[9:7], f[0], f[9:1], r[6:5], 1'b0};
			8: return {r[4], r[4] ? 3'h0 : r[9:7]};
			default: return 0;
		endcase
	endfunction
	function automatic logic [31:0] obs(logic [3:0] c);
		case (c)
			1: return {mode_reg_index, mode_reg_operand};
			2: return mode_reg_index;
			5: return {bank_select, row_index};
			6, 7: return {bank_select, auto_precharge_flag, column_index};
			8: return {all_banks_flag, bank_select};
			default: return 0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] s, x);
		n_tests++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h want %h", $time, s, x);
		end
	endtask
	task automatic end_sim;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic run(input logic cs, ke, input logic [9:0] r, f, input logic [3:0] x);
		n0 = nv;
		u_lpcd_ctrl.send(cs, ke, r, f);
		repeat (3) @(negedge clk);
		chk(nv, n0 + 1);
		chk(got, x);
		chk(obs(x), dig(x, r, f));
	endtask
	initial begin
		void'($urandom(32'h0622F825));
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		run(1, 1, 10'h000, 10'h3FF, `LPCD_CMD_PDX);
		for (int i = 0; i < 40; i++) begin
			e = T[i < 11 ? i : $urandom % 11];
			r = $urandom;
			f = $urandom;
			r[3:0] = (r[3:0] & ~e[7:4]) | e[3:0];
			run(e == 12'hE00, 1, r, f, e[11:8]);
		end
		chk(illegal_seen, 1);
		run(1, 0, r, f, `LPCD_CMD_PDE);
		run(1, 1, r, f, `LPCD_CMD_PDX);
		run(0, 0, 10'h3F4, f, `LPCD_CMD_SELF_REFRESH_MODE);
		chk(power_mode, `LPCD_PM_SELF_REFRESH_MODE);
		u_lpcd_ctrl.cke_up();
		repeat (6) @(negedge clk);
		chk(got, `LPCD_CMD_PDX);
		chk(power_mode, `LPCD_PM_ACTIVE);
		u_lpcd_ctrl.send(1, 1, r, f);
		run(0, 0, 10'h3F3, f, `LPCD_CMD_DPD);
		u_lpcd_ctrl.cke_up();
		repeat (6) @(negedge clk);
		chk(illegal_seen, 0);
		end_sim();
	end
	initial begin
		repeat (4000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
endmodule // tb_lpcd_decoder
